// *** design/host_pin_pkg.sv ***
// constants for the host port pin mux block
// assumes a single 125 MHz core clock domain
package host_pin_pkg;
    localparam int DATA_LOW_W = 8;
    localparam int DATA_HIGH_W = 8;
    localparam logic IF_SERIAL = 1'b1;
    localparam logic WIDTH_16 = 1'b1;
    // reset levels of the outputs
    localparam logic RST_FRAME_LOCK = 1'b0;
    localparam logic RST_BLOCK_LOCK = 1'b0;
    localparam logic RST_FRAME_START = 1'b0;
    localparam logic RST_BLOCK_START = 1'b0;
    localparam logic RST_RECOV_CLK = 1'b0;
    localparam logic RST_DEMOD_DATA = 1'b0;
    localparam logic RST_CRC_RESULT = 1'b1;
    localparam logic RST_DMA_REQ = 1'b1;
    localparam logic RST_READ_READY = 1'b1;
    localparam logic RST_IRQ = 1'b1;
    localparam logic [7:0] RST_DATA = 8'h00;
    // straps are sampled this many cycles after reset release
    localparam int STRAP_DELAY = 3;
endpackage : host_pin_pkg

// *** design/host_port_pins.sv ***
// host port pin mux: strap decode, pin sharing, reset states of digital outputs
// assumes core status comes synchronous; pins and link clock pass two flip-flops
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module host_port_pins
    import host_pin_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // straps and pins from outside
    input wire logic if_select_in,
    input wire logic bus_width_sel_in,
    input wire logic standby_req_in,
    input wire logic addr0_or_serial_clk_in,
    input wire logic addr1_or_serial_enable_in,
    input wire logic addr2_or_serial_din_in,
    input wire logic addr_bit3_in,
    input wire logic bus_dir_ctl_a_in,
    input wire logic bus_dir_ctl_b_in,
    input wire logic dma_acknowledge_in,
    input wire logic [DATA_LOW_W-1:0] data_low_lines_in,
    // core side, same clock
    input wire logic frame_sync_in,
    input wire logic block_sync_in,
    input wire logic frame_start_in,
    input wire logic block_start_in,
    input wire logic recovered_clk_in,
    input wire logic demod_data_in,
    input wire logic crc_result_in,
    input wire logic dma_request_in,
    input wire logic read_ready_in,
    input wire logic irq_b_in,
    input wire logic serial_dout_low_in,
    input wire logic [DATA_LOW_W-1:0] rd_data_low_in,
    input wire logic [DATA_HIGH_W-1:0] rd_data_high_in,
    input wire logic data_drive_in,
    // outputs to pins
    output logic frame_lock_flag_out,
    output logic block_lock_flag_out,
    output logic frame_start_pulse_out,
    output logic block_start_pulse_out,
    output logic recovered_clk_monitor_out,
    output logic demod_data_monitor_out,
    output logic upper_crc_result_out,
    output logic dma_request_out,
    output logic read_ready_out,
    output logic irq_b_out,
    output logic serial_dout_out,
    output logic serial_dout_oe_out,
    output logic [DATA_LOW_W-1:0] data_low_lines_out,
    output logic data_low_lines_oe_out,
    output logic [DATA_HIGH_W-1:0] data_high_lines_out,
    output logic data_high_lines_oe_out,
    // decoded pins toward core
    output logic serial_mode_out,
    output logic wide_bus_out,
    output logic standby_out,
    output logic serial_clk_rise_out,
    output logic serial_enable_out,
    output logic serial_din_out,
    output logic [3:0] addr_out
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers
    logic [12:0] meta_reg;
    logic [12:0] sync_reg;
    logic [DATA_LOW_W-1:0] dmeta_reg;
    logic [DATA_LOW_W-1:0] dsync_reg;
    wire logic [12:0] raw_pins = {data_drive_in, dma_acknowledge_in, bus_dir_ctl_b_in,
        bus_dir_ctl_a_in, addr_bit3_in, addr2_or_serial_din_in,
        addr1_or_serial_enable_in, addr0_or_serial_clk_in, standby_req_in,
        bus_width_sel_in, if_select_in, 2'b00};

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_reg <= 13'h0000;
            sync_reg <= 13'h0000;
        end
        else
        begin
            meta_reg <= raw_pins;
            sync_reg <= meta_reg;
        end
    end

    // data lines in a pair of their own, ready for the parallel write path
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dmeta_reg <= RST_DATA;
            dsync_reg <= RST_DATA;
        end
        else
        begin
            dmeta_reg <= data_low_lines_in;
            dsync_reg <= dmeta_reg;
        end
    end

    wire logic if_sel_s = sync_reg[2];
    wire logic width_s = sync_reg[3];
    wire logic standby_s = sync_reg[4];
    wire logic pin0_s = sync_reg[5];
    wire logic pin1_s = sync_reg[6];
    wire logic pin2_s = sync_reg[7];
    wire logic pin3_s = sync_reg[8];

////////////////////////////////////////////////////////////////////////////////
// strap capture after reset release; straps treated static afterwards
    logic [1:0] strap_cnt_reg;
    logic straps_ok_reg;
    logic serial_mode_reg;
    logic wide_bus_reg;
    wire logic strap_take = !straps_ok_reg && (strap_cnt_reg == 2'(STRAP_DELAY - 1));

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            strap_cnt_reg <= 2'h0;
            straps_ok_reg <= 1'b0;
            serial_mode_reg <= 1'b0;
            wide_bus_reg <= 1'b0;
        end
        else
        begin
            if (!straps_ok_reg)
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_take)
            begin
                straps_ok_reg <= 1'b1;
                serial_mode_reg <= (if_sel_s == IF_SERIAL);
                wide_bus_reg <= (width_s == WIDTH_16);
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// shared pin decode
    logic clk_prev_reg;
    wire logic serial_act = straps_ok_reg && serial_mode_reg;
    wire logic par_act = straps_ok_reg && !serial_mode_reg;
    wire logic clk_rise = serial_act && pin0_s && !clk_prev_reg;
    // all four address bits forced to zero outside parallel use, whatever the host drives
    wire logic [3:0] addr_dec = par_act ? {pin3_s, pin2_s, pin1_s, pin0_s} : 4'h0;
    wire logic drive_low = par_act && sync_reg[12] && !standby_s;
    wire logic drive_high = drive_low && wide_bus_reg;

    // parallel-only handshakes park at their idle level outside parallel use
    function automatic logic park_high(input logic active, input logic level);
        return active ? level : 1'b1;
    endfunction : park_high

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            clk_prev_reg <= 1'b0;
            serial_mode_out <= 1'b0;
            wide_bus_out <= 1'b0;
            standby_out <= 1'b0;
            serial_clk_rise_out <= 1'b0;
            serial_enable_out <= 1'b0;
            serial_din_out <= 1'b0;
            addr_out <= 4'h0;
        end
        else
        begin
            clk_prev_reg <= pin0_s;
            serial_mode_out <= serial_mode_reg;
            wide_bus_out <= wide_bus_reg;
            standby_out <= standby_s;
            serial_clk_rise_out <= clk_rise;
            // enable low is address phase, high is transfer phase
            serial_enable_out <= serial_act && pin1_s;
            serial_din_out <= serial_act && pin2_s;
            addr_out <= addr_dec;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// output pins; async reset forces documented levels at once
// sync flags
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            frame_lock_flag_out <= RST_FRAME_LOCK;
            block_lock_flag_out <= RST_BLOCK_LOCK;
        end
        else
        begin
            frame_lock_flag_out <= frame_sync_in;
            block_lock_flag_out <= block_sync_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            frame_start_pulse_out <= RST_FRAME_START;
            block_start_pulse_out <= RST_BLOCK_START;
        end
        else
        begin
            frame_start_pulse_out <= frame_start_in;
            block_start_pulse_out <= block_start_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            recovered_clk_monitor_out <= RST_RECOV_CLK;
            demod_data_monitor_out <= RST_DEMOD_DATA;
        end
        else
        begin
            recovered_clk_monitor_out <= recovered_clk_in;
            demod_data_monitor_out <= demod_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            upper_crc_result_out <= RST_CRC_RESULT;
        end
        else
        begin
            upper_crc_result_out <= crc_result_in;
        end
    end

    // parked high in serial use so a host strapped serially never sees a request
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dma_request_out <= RST_DMA_REQ;
            read_ready_out <= RST_READ_READY;
        end
        else
        begin
            dma_request_out <= park_high(par_act, dma_request_in);
            read_ready_out <= park_high(par_act, read_ready_in);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            irq_b_out <= RST_IRQ;
        end
        else
        begin
            irq_b_out <= irq_b_in;
        end
    end

    // open drain: only ever pulls low, the pull-up gives the high level
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            serial_dout_out <= 1'b0;
            serial_dout_oe_out <= 1'b0;
        end
        else
        begin
            serial_dout_out <= 1'b0;
            serial_dout_oe_out <= serial_act && serial_dout_low_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            data_low_lines_out <= RST_DATA;
            data_low_lines_oe_out <= 1'b0;
        end
        else
        begin
            data_low_lines_out <= rd_data_low_in;
            data_low_lines_oe_out <= drive_low;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            data_high_lines_out <= RST_DATA;
            data_high_lines_oe_out <= 1'b0;
        end
        else
        begin
            data_high_lines_out <= rd_data_high_in;
            data_high_lines_oe_out <= drive_high;
        end
    end

endmodule : host_port_pins

// *** sim/host_port_pins_monitor.sv ***
// checker for the host port pin mux
// assumes one clock domain; bound from the bench top
`timescale 1ns/100ps
module host_port_pins_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic frame_sync_in,
    input wire logic block_sync_in,
    input wire logic frame_start_in,
    input wire logic crc_result_in,
    input wire logic standby_req_in,
    input wire logic addr0_or_serial_clk_in,
    input wire logic frame_lock_flag_out,
    input wire logic block_lock_flag_out,
    input wire logic frame_start_pulse_out,
    input wire logic upper_crc_result_out,
    input wire logic serial_mode_out,
    input wire logic wide_bus_out,
    input wire logic standby_out,
    input wire logic serial_clk_rise_out,
    input wire logic data_high_lines_oe_out,
    input wire logic [3:0] addr_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // pin path is two sync stages and an output register
    sequence pin_rise_s;
        serial_mode_out && $rose(addr0_or_serial_clk_in);
    endsequence
    frame_lock_a: assert property ($rose(frame_sync_in) |=> frame_lock_flag_out)
        else $error("frame lock flag late");
    block_lock_a: assert property (!block_sync_in |=> !block_lock_flag_out)
        else $error("block lock flag stuck");
    frame_start_a: assert property (frame_start_in |=> frame_start_pulse_out)
        else $error("frame start missed");
    crc_follow_a: assert property (crc_result_in |=> upper_crc_result_out)
        else $error("checksum result wrong");
    high_lines_off_a: assert property (!wide_bus_out |-> !data_high_lines_oe_out)
        else $error("upper lines driven at 8 bits");
    serial_addr_a: assert property (serial_mode_out |-> addr_out == 4'h0)
        else $error("address leaks in serial mode");
    clk_edge_a: assert property (pin_rise_s |-> ##3 serial_clk_rise_out)
        else $error("serial clock edge lost");
    standby_entry_a: assert property ($rose(standby_req_in) |-> ##3 standby_out)
        else $error("standby not entered");
endmodule : host_port_pins_monitor

// *** sim/host_side_model.sv ***
// host cpu model: straps, shared pins and serial frames on a 64 ns link clock
// assumes the bench calls one task at a time
`timescale 1ns/100ps
module host_side_model (
    output logic if_select_out,
    output logic bus_width_sel_out,
    output logic [3:0] pins_out,
    output logic dir_ctl_out,
    output logic dma_ack_out,
    output logic [7:0] data_low_out
);
    // parallel strobes are unused here, so parked levels hold in both modes
    assign dir_ctl_out = 1'b0;
    assign data_low_out = 8'h00;
    assign dma_ack_out = 1'b1;
    task automatic set_mode(input logic s, input logic w);
        if_select_out = s; // only called while reset is held
        bus_width_sel_out = w;
        pins_out = 4'h0;
    endtask : set_mode
    task automatic put_addr(input logic [3:0] a);
        pins_out = a;
    endtask : put_addr
    task automatic send_frame(input logic [7:0] code);
        pins_out[1] = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            pins_out[2] = code[i];
            #32 pins_out[0] = 1'b1;
            #32 pins_out[0] = 1'b0;
        end
        pins_out[1] = 1'b1;
        // data released after hold: not the last bit
        pins_out[2] = ~code[7];
    endtask : send_frame
    initial set_mode(1'b0, 1'b0);
endmodule : host_side_model

// *** sim/host_port_pins_tb_top.sv ***
// bench top: drives core inputs, reset and the standby pin; the host model drives the other pins
// assumes the package and design compile first
`timescale 1ns/100ps
module host_port_pins_tb_top
    import host_pin_pkg::*;
;
    localparam logic [9:0] RST_VEC = {RST_IRQ, RST_READ_READY, RST_DMA_REQ, RST_CRC_RESULT,
        RST_DEMOD_DATA, RST_RECOV_CLK, RST_BLOCK_START, RST_FRAME_START, RST_BLOCK_LOCK,
        RST_FRAME_LOCK};
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic standby_req_in = 1'b0;
    logic serial_dout_low_in = 1'b1;
    logic data_drive_in = 1'b1;
    logic [9:0] cin = 10'h000;
    logic [7:0] rd_data_low_in = 8'h3C;
    logic [7:0] rd_data_high_in = 8'hC3;
    int n_mismatch = 0;
    int check_count = 0;
    int n_rise = 0;
    wire frame_sync_in, block_sync_in, frame_start_in, block_start_in, recovered_clk_in,
        demod_data_in, crc_result_in, dma_request_in, read_ready_in, irq_b_in, if_select_in,
        bus_width_sel_in, addr0_or_serial_clk_in, addr1_or_serial_enable_in,
        addr2_or_serial_din_in, addr_bit3_in, bus_dir_ctl_a_in, bus_dir_ctl_b_in,
        dma_acknowledge_in, frame_lock_flag_out, block_lock_flag_out, frame_start_pulse_out,
        block_start_pulse_out, recovered_clk_monitor_out, demod_data_monitor_out,
        upper_crc_result_out, dma_request_out, read_ready_out, irq_b_out, serial_dout_out,
        serial_dout_oe_out, data_low_lines_oe_out, data_high_lines_oe_out, serial_mode_out,
        wide_bus_out, standby_out, serial_clk_rise_out, serial_enable_out, serial_din_out;
    wire [7:0] data_low_lines_in, data_low_lines_out, data_high_lines_out;
    wire [3:0] addr_out;
    wire [9:0] cout = {irq_b_out, read_ready_out, dma_request_out, upper_crc_result_out,
        demod_data_monitor_out, recovered_clk_monitor_out, block_start_pulse_out,
        frame_start_pulse_out, block_lock_flag_out, frame_lock_flag_out};
    assign {irq_b_in, read_ready_in, dma_request_in, crc_result_in, demod_data_in,
        recovered_clk_in, block_start_in, frame_start_in, block_sync_in, frame_sync_in} = cin;
    assign bus_dir_ctl_b_in = bus_dir_ctl_a_in;
    host_port_pins DUT (.*);
    host_side_model HOST (.if_select_out(if_select_in), .bus_width_sel_out(bus_width_sel_in),
        .pins_out({addr_bit3_in, addr2_or_serial_din_in, addr1_or_serial_enable_in,
        addr0_or_serial_clk_in}), .dir_ctl_out(bus_dir_ctl_a_in),
        .dma_ack_out(dma_acknowledge_in), .data_low_out(data_low_lines_in));
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (serial_clk_rise_out === 1'b1) n_rise++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // core inputs sit opposite their reset levels so a leak shows
    task automatic reset_with(input logic s, input logic w);
        @(posedge ref_clk_in);
        rst_b_in <= 1'b0;
        cin <= ~RST_VEC;
        HOST.set_mode(s, w);
        repeat (3) @(posedge ref_clk_in);
        #1;
        check(cout, RST_VEC);
        check({data_low_lines_oe_out, data_high_lines_oe_out}, 2'h0);
        check(serial_dout_oe_out, 1'b0);
        @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        repeat (STRAP_DELAY + 3) @(posedge ref_clk_in);
        #1;
        check({serial_mode_out, wide_bus_out}, {s, w});
    endtask : reset_with
    task automatic t_parallel(input logic w);
        reset_with(1'b0, w);
        HOST.put_addr(4'hB);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge ref_clk_in);
            cin <= i ? 10'h155 : 10'h2AA;
            @(posedge ref_clk_in);
            #1;
            check(cout, i ? 10'h155 : 10'h2AA);
        end
        check({data_low_lines_oe_out, data_low_lines_out}, {1'b1, 8'h3C});
        check(addr_out, 4'hB);
        check(data_high_lines_oe_out, w);
        if (w) check(data_high_lines_out, 8'hC3);
        check(serial_dout_oe_out, 1'b0);
        @(posedge ref_clk_in);
        standby_req_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        #1;
        check({standby_out, data_high_lines_oe_out}, 2'h2);
        @(posedge ref_clk_in);
        standby_req_in <= 1'b0;
    endtask : t_parallel
    task automatic t_serial;
        reset_with(1'b1, 1'b0);
        @(posedge ref_clk_in);
        cin <= 10'h000;
        n_rise = 0;
        #3;
        HOST.send_frame(8'hB6);
        repeat (4) @(posedge ref_clk_in);
        #1;
        check(n_rise, 16'h8);
        check(cout, 10'h180);
        check({serial_enable_out, addr_out}, 5'h10);
        check(serial_dout_oe_out, 1'b1);
        check({data_low_lines_oe_out, serial_dout_out, serial_din_out}, 3'h0);
    endtask : t_serial
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    initial
    begin
        t_parallel(1'b1);
        t_parallel(1'b0);
        t_serial;
        end_sim;
    end
endmodule : host_port_pins_tb_top
bind host_port_pins host_port_pins_monitor MON (.*);
